// File: dtp_pkg.sv
// Constants, types and helper functions for the DMA trigger and priority control block
package dtp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // Sizes
   localparam int NUM_CH   = 8;
   localparam int CH_W     = 3;
   localparam int NUM_HI   = 4;
   localparam int HI_BASE  = 4;
   localparam int NUM_TRIG = 32;
   localparam int TSEL_W   = 5;
   localparam int ADDR_W   = 8;
   localparam int DATA_W   = 32;
   localparam int REG_W    = 16;

   ////////////////////////////////////////////////////////////////////////////
   // Register offsets (byte addresses)
   localparam logic [ADDR_W-1:0] OFS_TRIG45  = 8'h00;
   localparam logic [ADDR_W-1:0] OFS_TRIG67  = 8'h04;
   localparam logic [ADDR_W-1:0] OFS_OPTS    = 8'h08;
   localparam logic [ADDR_W-1:0] OFS_IRQ_STS = 8'h0C;
   localparam logic [ADDR_W-1:0] OFS_IRQ_MSK = 8'h10;
   localparam logic [ADDR_W-1:0] OFS_ABORT   = 8'h14;

   ////////////////////////////////////////////////////////////////////////////
   // Field layout and reset values
   localparam int TSEL_LO_LSB   = 0;
   localparam int TSEL_HI_LSB   = 8;
   localparam int OPT_NMI_BIT   = 0;
   localparam int OPT_RR_BIT    = 1;
   localparam int OPT_RMW_BIT   = 2;
   localparam int IRQ_DONE_BIT  = 0;
   localparam int IRQ_ABORT_BIT = 1;
   localparam logic [REG_W-1:0] TSEL_MASK  = 16'h1F1F;
   localparam logic [REG_W-1:0] OPTS_MASK  = 16'h0007;
   localparam logic [REG_W-1:0] IRQ_MASK   = 16'h0003;
   localparam logic [REG_W-1:0] ABORT_MASK = 16'h00FF;
   localparam logic [REG_W-1:0] REG_RST    = 16'h0000;
   localparam logic [REG_W-1:0] REG_ZERO   = 16'h0000;
   localparam logic [1:0]       RESP_OKAY   = 2'h0;
   localparam logic [1:0]       RESP_SLVERR = 2'h2;

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer states
   typedef enum logic [1:0] {DTP_IDLE, DTP_XFER, DTP_STOP} dtp_state_t;

   ////////////////////////////////////////////////////////////////////////////
   // Byte-lane merge of a write into a 16-bit register
   function automatic logic [REG_W-1:0] dtp_wmerge(input logic [REG_W-1:0] old,
                                                   input logic [DATA_W-1:0] wdata,
                                                   input logic [3:0] strb,
                                                   input logic [REG_W-1:0] mask);
      logic [REG_W-1:0] res;
      res = old;
      if (strb[0]) begin
         res[7:0] = wdata[7:0];
      end
      if (strb[1]) begin
         res[15:8] = wdata[15:8];
      end
      return res & mask;
   endfunction

   // Lowest set request index
   function automatic logic [CH_W-1:0] dtp_first_set(input logic [NUM_CH-1:0] req);
      logic [CH_W-1:0] idx;
      idx = '0;
      for (int i = NUM_CH - 1; i >= 0; i--) begin
         if (req[i]) begin
            idx = (CH_W)'(i);
         end
      end
      return idx;
   endfunction

endpackage

// File: dtp_arbiter.sv
// Channel arbiter with fixed or rotating priority order
`timescale 1ns/1ps
module dtp_arbiter (
   input  wire logic                        core_clk_i,
   input  wire logic                        rst_n_i,
   input  wire logic [dtp_pkg::NUM_CH-1:0]  req_i,
   input  wire logic                        rotate_i,
   input  wire logic                        advance_i,
   input  wire logic [dtp_pkg::CH_W-1:0]    adv_ch_i,
   output logic                             gnt_valid_o,
   output logic [dtp_pkg::CH_W-1:0]         gnt_ch_o
);

   logic [dtp_pkg::CH_W-1:0] order_r   [dtp_pkg::NUM_CH];
   logic [dtp_pkg::CH_W-1:0] order_nxt [dtp_pkg::NUM_CH];
   logic [dtp_pkg::CH_W-1:0] eff       [dtp_pkg::NUM_CH];

   ////////////////////////////////////////////////////////////////////////////
   // Effective order: identity in fixed mode
   for (genvar g = 0; g < dtp_pkg::NUM_CH; g++) begin : g_eff
      assign eff[g] = rotate_i ? order_r[g] : (dtp_pkg::CH_W)'(g); // [R4]
   end

   // Lowest-numbered position with a pending request wins
   always_comb begin
      gnt_valid_o = 1'b0;
      gnt_ch_o    = '0;
      for (int i = dtp_pkg::NUM_CH - 1; i >= 0; i--) begin
         if (req_i[eff[i]]) begin
            gnt_valid_o = 1'b1;
            gnt_ch_o    = eff[i];
         end
      end
   end

   // Served channel drops to the bottom, the channels below it move up one place
   always_comb begin
      logic passed;
      passed = 1'b0;
      for (int i = 0; i < dtp_pkg::NUM_CH; i++) begin
         order_nxt[i] = eff[i];
      end
      if (advance_i && rotate_i) begin // [R5]
         for (int i = 0; i < dtp_pkg::NUM_CH - 1; i++) begin
            if (eff[i] == adv_ch_i) begin
               passed = 1'b1;
            end
            if (passed) begin
               order_nxt[i] = eff[i + 1]; // [R8]
            end
         end
         order_nxt[dtp_pkg::NUM_CH-1] = adv_ch_i; // [R8]
      end
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         for (int i = 0; i < dtp_pkg::NUM_CH; i++) begin
            order_r[i] <= (dtp_pkg::CH_W)'(i);
         end
      end else begin
         order_r <= order_nxt;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   AST_RR_LAST: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R8]
      advance_i && rotate_i |=> order_r[dtp_pkg::NUM_CH-1] == $past(adv_ch_i))
      else $error("Served channel not moved to lowest priority");
   AST_RR_CHANGE: assert property (@(posedge core_clk_i) disable iff (!rst_n_i) // [R5]
      advance_i && rotate_i && eff[dtp_pkg::NUM_CH-1] != adv_ch_i
      |=> order_r[dtp_pkg::NUM_CH-1] != $past(eff[dtp_pkg::NUM_CH-1]))
      else $error("Priority order unchanged after transfer");

endmodule // dtp_arbiter

// File: dtp_ctrl.sv
// DMA global control: trigger select, priority mode, RMW block, NMI abort, AXI4-Lite slave
//
// Overview of operation
// [R1]: Channels 4-7 select trigger 0-31 with 5-bit fields at bits 12-8 and 4-0.
// [R2]: Reserved bits read as zero; writes to them are ignored.
// [R3]: With RMW block set, no transfer starts during a CPU read-modify-write.
// [R4]: With rotating priority clear, channel 0 is highest down to channel 7.
// [R5]: With rotating priority set, the priority order changes after every transfer. The code keeps the order when the served channel is already lowest.
// [R6]: With NMI abort on, NMI finishes current transfer, stops others, sets abort flag.
// [R7]: With NMI abort off, an NMI never interrupts or stops transfers.
// [R8]: Rotating mode moves the served channel to lowest, others shift up in order.
`timescale 1ns/1ps
module dtp_ctrl (
   input  wire logic                          core_clk_i,
   input  wire logic                          rst_n_i,
   // AXI4-Lite slave
   input  wire logic [dtp_pkg::ADDR_W-1:0]    s_axi_awaddr_i,
   input  wire logic                          s_axi_awvalid_i,
   output logic                               s_axi_awready_o,
   input  wire logic [dtp_pkg::DATA_W-1:0]    s_axi_wdata_i,
   input  wire logic [3:0]                    s_axi_wstrb_i,
   input  wire logic                          s_axi_wvalid_i,
   output logic                               s_axi_wready_o,
   output logic [1:0]                         s_axi_bresp_o,
   output logic                               s_axi_bvalid_o,
   input  wire logic                          s_axi_bready_i,
   input  wire logic [dtp_pkg::ADDR_W-1:0]    s_axi_araddr_i,
   input  wire logic                          s_axi_arvalid_i,
   output logic                               s_axi_arready_o,
   output logic [dtp_pkg::DATA_W-1:0]         s_axi_rdata_o,
   output logic [1:0]                         s_axi_rresp_o,
   output logic                               s_axi_rvalid_o,
   input  wire logic                          s_axi_rready_i,
   // Channel requests and triggers
   input  wire logic [dtp_pkg::HI_BASE-1:0]   ch_req_lo_i,
   input  wire logic [dtp_pkg::NUM_TRIG-1:0]  trig_i,
   input  wire logic                          cpu_rmw_i,
   input  wire logic                          nmi_i,
   // Transfer engine handshake
   output logic                               xfer_start_o,
   output logic [dtp_pkg::CH_W-1:0]           xfer_ch_o,
   input  wire logic                          xfer_done_i,
   // Selected triggers, abort flags and interrupt
   output logic [dtp_pkg::TSEL_W-1:0]         trigger_select_ch4_o,
   output logic [dtp_pkg::TSEL_W-1:0]         trigger_select_ch5_o,
   output logic [dtp_pkg::TSEL_W-1:0]         trigger_select_ch6_o,
   output logic [dtp_pkg::TSEL_W-1:0]         trigger_select_ch7_o,
   output logic [dtp_pkg::NUM_CH-1:0]         channel_abort_flag_o,
   output logic                               irq_o
);

   ////////////////////////////////////////////////////////////////////////////
   // Declarations
   logic [dtp_pkg::REG_W-1:0]   tsel45_r;
   logic [dtp_pkg::REG_W-1:0]   tsel67_r;
   logic [dtp_pkg::REG_W-1:0]   opts_r;
   logic [dtp_pkg::REG_W-1:0]   irq_sts_r;
   logic [dtp_pkg::REG_W-1:0]   irq_msk_r;
   logic [dtp_pkg::REG_W-1:0]   abort_r;
   logic [dtp_pkg::REG_W-1:0]   irq_sts_nxt;
   logic [dtp_pkg::REG_W-1:0]   abort_nxt;
   logic                        awready_r;
   logic                        bvalid_r;
   logic [1:0]                  bresp_r;
   logic                        arready_r;
   logic                        rvalid_r;
   logic [1:0]                  rresp_r;
   logic [dtp_pkg::DATA_W-1:0]  rdata_r;
   logic                        irq_r;
   logic                        xfer_start_r;
   logic [dtp_pkg::CH_W-1:0]    xfer_ch_r;
   logic                        nmi_seen_r;
   dtp_pkg::dtp_state_t         state_r;
   dtp_pkg::dtp_state_t         state_nxt;

   ////////////////////////////////////////////////////////////////////////////
   // Write address decode
   wire wr_en        = awready_r && s_axi_awvalid_i && s_axi_wvalid_i;
   wire wr_hit_t45   = s_axi_awaddr_i == dtp_pkg::OFS_TRIG45;
   wire wr_hit_t67   = s_axi_awaddr_i == dtp_pkg::OFS_TRIG67;
   wire wr_hit_opts  = s_axi_awaddr_i == dtp_pkg::OFS_OPTS;
   wire wr_hit_sts   = s_axi_awaddr_i == dtp_pkg::OFS_IRQ_STS;
   wire wr_hit_msk   = s_axi_awaddr_i == dtp_pkg::OFS_IRQ_MSK;
   wire wr_hit_abort = s_axi_awaddr_i == dtp_pkg::OFS_ABORT;
   wire wr_mapped    = wr_hit_t45 | wr_hit_t67 | wr_hit_opts | wr_hit_sts | wr_hit_msk | wr_hit_abort;

   // Write-one-to-clear masks
   wire [dtp_pkg::REG_W-1:0] sts_clr = (wr_en && wr_hit_sts) ?
      dtp_pkg::dtp_wmerge(dtp_pkg::REG_ZERO, s_axi_wdata_i, s_axi_wstrb_i, dtp_pkg::IRQ_MASK) : dtp_pkg::REG_ZERO;
   wire [dtp_pkg::REG_W-1:0] abort_clr = (wr_en && wr_hit_abort) ?
      dtp_pkg::dtp_wmerge(dtp_pkg::REG_ZERO, s_axi_wdata_i, s_axi_wstrb_i, dtp_pkg::ABORT_MASK) : dtp_pkg::REG_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // Read address decode
   wire rd_en        = arready_r && s_axi_arvalid_i;
   wire rd_hit_t45   = s_axi_araddr_i == dtp_pkg::OFS_TRIG45;
   wire rd_hit_t67   = s_axi_araddr_i == dtp_pkg::OFS_TRIG67;
   wire rd_hit_opts  = s_axi_araddr_i == dtp_pkg::OFS_OPTS;
   wire rd_hit_sts   = s_axi_araddr_i == dtp_pkg::OFS_IRQ_STS;
   wire rd_hit_msk   = s_axi_araddr_i == dtp_pkg::OFS_IRQ_MSK;
   wire rd_hit_abort = s_axi_araddr_i == dtp_pkg::OFS_ABORT;
   wire rd_mapped    = rd_hit_t45 | rd_hit_t67 | rd_hit_opts | rd_hit_sts | rd_hit_msk | rd_hit_abort;
   wire [dtp_pkg::REG_W-1:0] rd_data16 =
      rd_hit_t45   ? tsel45_r  :
      rd_hit_t67   ? tsel67_r  :
      rd_hit_opts  ? opts_r    :
      rd_hit_sts   ? irq_sts_r :
      rd_hit_msk   ? irq_msk_r :
      rd_hit_abort ? abort_r   : dtp_pkg::REG_ZERO;

   ////////////////////////////////////////////////////////////////////////////
   // Option bits and trigger routing
   wire opt_nmi = opts_r[dtp_pkg::OPT_NMI_BIT];
   wire opt_rr  = opts_r[dtp_pkg::OPT_RR_BIT];
   wire opt_rmw = opts_r[dtp_pkg::OPT_RMW_BIT];

   logic [dtp_pkg::TSEL_W-1:0] tsel_hi [dtp_pkg::NUM_HI];
   logic [dtp_pkg::NUM_CH-1:0] req_all;
   assign tsel_hi[0] = tsel45_r[dtp_pkg::TSEL_LO_LSB +: dtp_pkg::TSEL_W]; // [R1]
   assign tsel_hi[1] = tsel45_r[dtp_pkg::TSEL_HI_LSB +: dtp_pkg::TSEL_W]; // [R1]
   assign tsel_hi[2] = tsel67_r[dtp_pkg::TSEL_LO_LSB +: dtp_pkg::TSEL_W]; // [R1]
   assign tsel_hi[3] = tsel67_r[dtp_pkg::TSEL_HI_LSB +: dtp_pkg::TSEL_W]; // [R1]
   assign req_all[dtp_pkg::HI_BASE-1:0] = ch_req_lo_i;
   for (genvar k = 0; k < dtp_pkg::NUM_HI; k++) begin : g_trig
      assign req_all[dtp_pkg::HI_BASE+k] = trig_i[tsel_hi[k]]; // [R1]
   end

   ////////////////////////////////////////////////////////////////////////////
   // Arbiter
   logic                     gnt_valid;
   logic [dtp_pkg::CH_W-1:0] gnt_ch;
   wire xfer_end = (state_r == dtp_pkg::DTP_XFER) && xfer_done_i;
   wire nmi_hit  = opt_nmi && (nmi_seen_r || nmi_i); // [R6] [R7]
   wire rmw_hold = opt_rmw && cpu_rmw_i; // [R3]
   wire start_ok = (state_r == dtp_pkg::DTP_IDLE) && gnt_valid && !rmw_hold; // [R3]

   dtp_arbiter u_arb (
      .core_clk_i  (core_clk_i),
      .rst_n_i     (rst_n_i),
      .req_i       (req_all),
      .rotate_i    (opt_rr),
      .advance_i   (xfer_end),
      .adv_ch_i    (xfer_ch_r),
      .gnt_valid_o (gnt_valid),
      .gnt_ch_o    (gnt_ch)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Transfer sequencer
   always_comb begin
      state_nxt = state_r;
      case (state_r)
         dtp_pkg::DTP_IDLE: begin
            if (start_ok) begin
               state_nxt = dtp_pkg::DTP_XFER;
            end
         end
         dtp_pkg::DTP_XFER: begin
            if (xfer_done_i) begin
               state_nxt = nmi_hit ? dtp_pkg::DTP_STOP : dtp_pkg::DTP_IDLE; // [R6] [R7]
            end
         end
         dtp_pkg::DTP_STOP: begin
            if (abort_r == dtp_pkg::REG_ZERO) begin
               state_nxt = dtp_pkg::DTP_IDLE;
            end
         end
         default: begin
            state_nxt = dtp_pkg::DTP_IDLE;
         end
      endcase
   end

   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         state_r      <= dtp_pkg::DTP_IDLE;
         xfer_start_r <= 1'b0;
         xfer_ch_r    <= '0;
         nmi_seen_r   <= 1'b0;
      end else begin
         state_r      <= state_nxt;
         xfer_start_r <= start_ok;
         if (start_ok) begin
            xfer_ch_r <= gnt_ch;
         end
         nmi_seen_r   <= (state_r == dtp_pkg::DTP_XFER) && !xfer_done_i && nmi_hit; // [R6]
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sticky flags: set wins over clear
   wire abort_evt = xfer_end && nmi_hit;
   wire [dtp_pkg::REG_W-1:0] abort_set = abort_evt ?
      (dtp_pkg::REG_W)'({{(dtp_pkg::NUM_CH-1){1'b0}}, 1'b1} << xfer_ch_r) : dtp_pkg::REG_ZERO;
   assign abort_nxt = (abort_r & ~abort_clr) | abort_set; // [R6]
   always_comb begin
      irq_sts_nxt = irq_sts_r & ~sts_clr;
      irq_sts_nxt[dtp_pkg::IRQ_DONE_BIT]  = irq_sts_nxt[dtp_pkg::IRQ_DONE_BIT] | xfer_end;
      irq_sts_nxt[dtp_pkg::IRQ_ABORT_BIT] = irq_sts_nxt[dtp_pkg::IRQ_ABORT_BIT] | abort_evt;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Registers
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         tsel45_r  <= dtp_pkg::REG_RST;
         tsel67_r  <= dtp_pkg::REG_RST;
         opts_r    <= dtp_pkg::REG_RST;
         irq_msk_r <= dtp_pkg::REG_RST;
         irq_sts_r <= dtp_pkg::REG_RST;
         abort_r   <= dtp_pkg::REG_RST;
         irq_r     <= 1'b0;
      end else begin
         if (wr_en && wr_hit_t45) begin
            tsel45_r <= dtp_pkg::dtp_wmerge(tsel45_r, s_axi_wdata_i, s_axi_wstrb_i, dtp_pkg::TSEL_MASK); // [R2]
         end
         if (wr_en && wr_hit_t67) begin
            tsel67_r <= dtp_pkg::dtp_wmerge(tsel67_r, s_axi_wdata_i, s_axi_wstrb_i, dtp_pkg::TSEL_MASK); // [R2]
         end
         if (wr_en && wr_hit_opts) begin
            opts_r <= dtp_pkg::dtp_wmerge(opts_r, s_axi_wdata_i, s_axi_wstrb_i, dtp_pkg::OPTS_MASK); // [R2]
         end
         if (wr_en && wr_hit_msk) begin
            irq_msk_r <= dtp_pkg::dtp_wmerge(irq_msk_r, s_axi_wdata_i, s_axi_wstrb_i, dtp_pkg::IRQ_MASK);
         end
         irq_sts_r <= irq_sts_nxt;
         abort_r   <= abort_nxt;
         irq_r     <= |(irq_sts_r & irq_msk_r);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // AXI4-Lite handshakes
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         awready_r <= 1'b0;
         bvalid_r  <= 1'b0;
         bresp_r   <= dtp_pkg::RESP_OKAY;
         arready_r <= 1'b0;
         rvalid_r  <= 1'b0;
         rresp_r   <= dtp_pkg::RESP_OKAY;
         rdata_r   <= '0;
      end else begin
         awready_r <= s_axi_awvalid_i && s_axi_wvalid_i && !awready_r && !bvalid_r;
         if (wr_en) begin
            bvalid_r <= 1'b1;
            bresp_r  <= wr_mapped ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
         end else if (s_axi_bready_i) begin
            bvalid_r <= 1'b0;
         end
         arready_r <= s_axi_arvalid_i && !arready_r && !rvalid_r;
         if (rd_en) begin
            rvalid_r <= 1'b1;
            rresp_r  <= rd_mapped ? dtp_pkg::RESP_OKAY : dtp_pkg::RESP_SLVERR;
            rdata_r  <= {dtp_pkg::REG_ZERO, rd_data16}; // [R2]
         end else if (s_axi_rready_i) begin
            rvalid_r <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   assign s_axi_awready_o      = awready_r;
   assign s_axi_wready_o       = awready_r;
   assign s_axi_bvalid_o       = bvalid_r;
   assign s_axi_bresp_o        = bresp_r;
   assign s_axi_arready_o      = arready_r;
   assign s_axi_rvalid_o       = rvalid_r;
   assign s_axi_rresp_o        = rresp_r;
   assign s_axi_rdata_o        = rdata_r;
   assign xfer_start_o         = xfer_start_r;
   assign xfer_ch_o            = xfer_ch_r;
   assign trigger_select_ch4_o = tsel_hi[0];
   assign trigger_select_ch5_o = tsel_hi[1];
   assign trigger_select_ch6_o = tsel_hi[2];
   assign trigger_select_ch7_o = tsel_hi[3];
   assign channel_abort_flag_o = abort_r[dtp_pkg::NUM_CH-1:0];
   assign irq_o                = irq_r;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   default clocking cb @(posedge core_clk_i); endclocking
   default disable iff (!rst_n_i);

   wire [dtp_pkg::CH_W-1:0] fixed_pick = dtp_pkg::dtp_first_set(req_all);
   wire full_strb = s_axi_wstrb_i[0] && s_axi_wstrb_i[1];

   AST_TSEL_WR: assert property ( // [R1]
      wr_en && wr_hit_t45 && full_strb |=> trigger_select_ch5_o == $past(s_axi_wdata_i[12:8])
                                           && trigger_select_ch4_o == $past(s_axi_wdata_i[4:0]))
      else $error("Trigger select field not written");

   AST_RSV_ZERO: assert property ( // [R2]
      s_axi_rvalid_o |-> s_axi_rdata_o[31:13] == '0 && opts_r[15:3] == '0)
      else $error("Reserved bits not zero");

   AST_RMW_BLOCK: assert property ( // [R3]
      state_r == dtp_pkg::DTP_IDLE && opt_rmw && cpu_rmw_i |=> !xfer_start_o)
      else $error("Transfer started during CPU read-modify-write");

   AST_FIXED_PRIO: assert property ( // [R4]
      start_ok && !opt_rr |=> xfer_start_o && xfer_ch_o == $past(fixed_pick))
      else $error("Fixed priority not honoured");

   AST_NMI_STOP: assert property ( // [R6]
      xfer_end && nmi_hit |=> state_r == dtp_pkg::DTP_STOP && channel_abort_flag_o[$past(xfer_ch_r)])
      else $error("NMI abort not taken");

   AST_STOP_HOLD: assert property ( // [R6]
      state_r == dtp_pkg::DTP_STOP |=> !xfer_start_o)
      else $error("Transfer started while stopped");

   AST_NMI_IGNORE: assert property ( // [R7]
      xfer_end && !opt_nmi |=> state_r == dtp_pkg::DTP_IDLE && !$rose(channel_abort_flag_o[xfer_ch_r]))
      else $error("NMI stopped transfers while disabled");

   AST_WR_RESP: assert property (
      wr_en |=> s_axi_bvalid_o)
      else $error("Write response missing");

   AST_RD_RESP: assert property (
      rd_en |=> s_axi_rvalid_o)
      else $error("No read response");

   AST_DONE_STS: assert property (
      xfer_end |=> irq_sts_r[dtp_pkg::IRQ_DONE_BIT])
      else $error("Done flag lost");

   COV_ABORT: cover property (xfer_end && nmi_hit);

   COV_RMW: cover property (state_r == dtp_pkg::DTP_IDLE && gnt_valid && rmw_hold);

   COV_RR: cover property (xfer_end && opt_rr ##[1:20] xfer_start_o);

   COV_STOP_EXIT: cover property (state_r == dtp_pkg::DTP_STOP
      ##1 state_r == dtp_pkg::DTP_IDLE);

   COV_ROUTE: cover property (xfer_start_o && xfer_ch_o >= dtp_pkg::HI_BASE);

endmodule // dtp_ctrl

// File: dtp_engine_model.sv
// Transfer engine stand-in: answers each start with one done pulse
`timescale 1ns/1ps
module dtp_engine_model (
   input  wire logic core_clk_i,
   input  wire logic rst_n_i,
   input  wire logic xfer_start_i,
   input  wire logic slow_i,
   output logic      xfer_done_o
);
   logic [2:0] cnt_r;
   always_ff @(posedge core_clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r       <= 3'h0;
         xfer_done_o <= 1'b0;
      end else begin
         xfer_done_o <= (cnt_r == 3'h1);
         if (xfer_start_i) cnt_r <= slow_i ? 3'h5 : 3'h1;
         else if (cnt_r != 3'h0) cnt_r <= cnt_r - 3'h1;
      end
   end
endmodule // dtp_engine_model

// File: tb_dma_trigger_priority_control.sv
// Testbench for the DMA trigger and priority control block
`timescale 1ns/1ps
module tb_dma_trigger_priority_control;
   logic [7:0]  s_axi_awaddr_i, s_axi_araddr_i, channel_abort_flag_o;
   logic [31:0] s_axi_wdata_i, s_axi_rdata_o, trig_i;
   logic [3:0]  s_axi_wstrb_i, ch_req_lo_i;
   logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
   logic [2:0]  xfer_ch_o;
   logic [4:0]  trigger_select_ch4_o, trigger_select_ch5_o, trigger_select_ch6_o, trigger_select_ch7_o;
   logic        core_clk_i, rst_n_i, s_axi_awvalid_i, s_axi_awready_o, s_axi_wvalid_i, s_axi_wready_o;
   logic        s_axi_bvalid_o, s_axi_bready_i, s_axi_arvalid_i, s_axi_arready_o, s_axi_rvalid_o, s_axi_rready_i;
   logic        cpu_rmw_i, nmi_i, xfer_start_o, xfer_done_i, irq_o, slow;
   int          failures = 0, compares = 0, cyc = 0;

   dtp_ctrl u_dut (.*);
   dtp_engine_model u_eng (.core_clk_i, .rst_n_i, .xfer_start_i(xfer_start_o), .slow_i(slow), .xfer_done_o(xfer_done_i));

   ////////////////////////////////////////////////////////////////////////////
   // Checking, bus and transfer tasks
   task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
      compares++;
      if (got !== exp) begin
         failures++;
         $display("unexpected at %0t: %s got %h expected %h", $time, m, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0);
      @(posedge core_clk_i);
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      s_axi_bready_i <= 1'b1;
      do @(posedge core_clk_i); while (!(s_axi_awready_o && s_axi_wready_o));
      s_axi_awvalid_i <= 1'b0;
      s_axi_wvalid_i <= 1'b0;
      do @(posedge core_clk_i); while (!s_axi_bvalid_o);
      s_axi_bready_i <= 1'b0;
      chk(s_axi_bresp_o, er, "write response");
   endtask
   task automatic rdr(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
      @(posedge core_clk_i);
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      s_axi_rready_i <= 1'b1;
      do @(posedge core_clk_i); while (!s_axi_arready_o);
      s_axi_arvalid_i <= 1'b0;
      do @(posedge core_clk_i); while (!s_axi_rvalid_o);
      s_axi_rready_i <= 1'b0;
      chk(s_axi_rdata_o, exp, "read data");
      chk(s_axi_rresp_o, er, "read response");
   endtask
   task automatic xfer(input logic [3:0] lo, input logic [31:0] tr, input logic [2:0] ch, input logic nm = 1'b0);
      int n;
      n = 0;
      @(posedge core_clk_i);
      ch_req_lo_i <= lo;
      trig_i <= tr;
      do begin
         @(posedge core_clk_i);
         n++;
      end while (!xfer_start_o && n < 20);
      chk(xfer_start_o, 1'b1, "start");
      chk(xfer_ch_o, ch, "grant");
      ch_req_lo_i <= 4'h0;
      trig_i <= 32'h0000_0000;
      nmi_i <= nm;
      do @(posedge core_clk_i); while (!xfer_done_i);
      nmi_i <= 1'b0;
      repeat (3) @(posedge core_clk_i);
   endtask
   task automatic no_start(input logic [3:0] lo);
      logic seen;
      seen = 1'b0;
      @(posedge core_clk_i);
      ch_req_lo_i <= lo;
      repeat (6) begin
         @(posedge core_clk_i);
         seen = seen | xfer_start_o;
      end
      ch_req_lo_i <= 4'h0;
      chk(seen, 1'b0, "blocked");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Scenarios
   task automatic t_regs();
      rdr(dtp_pkg::OFS_OPTS, 32'h0000_0000);
      wr(dtp_pkg::OFS_TRIG45, 32'hFFFF_FFFF);
      wr(dtp_pkg::OFS_TRIG67, 32'hFFFF_FFFF);
      wr(dtp_pkg::OFS_OPTS, 32'hFFFF_FFFF);
      rdr(dtp_pkg::OFS_TRIG45, 32'h0000_1F1F);
      rdr(dtp_pkg::OFS_TRIG67, 32'h0000_1F1F);
      rdr(dtp_pkg::OFS_OPTS, 32'h0000_0007);
      chk(trigger_select_ch7_o, 32'h0000_001F, "select ch7");
      wr(8'h1C, 32'hFFFF_FFFF, dtp_pkg::RESP_SLVERR);
      rdr(8'h1C, 32'h0000_0000, dtp_pkg::RESP_SLVERR);
      wr(dtp_pkg::OFS_OPTS, 32'h0000_0000);
      $display("test regs done");
   endtask
   task automatic t_route();
      wr(dtp_pkg::OFS_TRIG45, 32'h0000_1F03);
      wr(dtp_pkg::OFS_TRIG67, 32'h0000_1000);
      chk(trigger_select_ch5_o, 32'h0000_001F, "select ch5");
      chk({trigger_select_ch4_o, trigger_select_ch6_o}, 32'h0000_0060, "select 4 6");
      xfer(4'h0, 32'h0000_0008, 3'h4);
      xfer(4'h0, 32'h8000_0000, 3'h5);
      xfer(4'h0, 32'h0000_0001, 3'h6);
      xfer(4'h0, 32'h0001_0000, 3'h7);
      $display("test routing done");
   endtask
   task automatic t_prio();
      xfer(4'hA, 32'h0000_0000, 3'h1);
      xfer(4'h8, 32'h0001_0008, 3'h3);
      wr(dtp_pkg::OFS_OPTS, 32'h0000_0002);
      for (int i = 0; i < 4; i++) xfer(4'hF, 32'h0000_0000, 3'(i));
      xfer(4'h1, 32'h0001_0000, 3'h7);
      wr(dtp_pkg::OFS_OPTS, 32'h0000_0000);
      xfer(4'h1, 32'h0001_0000, 3'h0);
      $display("test prio done");
   endtask
   task automatic t_rmw();
      cpu_rmw_i <= 1'b1;
      xfer(4'h1, 32'h0000_0000, 3'h0);
      wr(dtp_pkg::OFS_OPTS, 32'h0000_0004);
      no_start(4'h1);
      cpu_rmw_i <= 1'b0;
      xfer(4'h1, 32'h0000_0000, 3'h0);
      wr(dtp_pkg::OFS_OPTS, 32'h0000_0000);
      $display("test rmw done");
   endtask
   task automatic t_nmi();
      slow <= 1'b1;
      wr(dtp_pkg::OFS_IRQ_MSK, 32'h0000_0003);
      xfer(4'h2, 32'h0000_0000, 3'h1, 1'b1);
      chk(channel_abort_flag_o, 32'h0000_0000, "abort flags");
      chk(irq_o, 1'b1, "done irq");
      xfer(4'h2, 32'h0000_0000, 3'h1);
      wr(dtp_pkg::OFS_IRQ_STS, 32'h0000_0003);
      repeat (2) @(posedge core_clk_i);
      chk(irq_o, 1'b0, "irq cleared");
      wr(dtp_pkg::OFS_OPTS, 32'h0000_0001);
      xfer(4'h4, 32'h0000_0000, 3'h2, 1'b1);
      chk(channel_abort_flag_o, 32'h0000_0004, "abort flag");
      chk(irq_o, 1'b1, "abort irq");
      no_start(4'h1);
      rdr(dtp_pkg::OFS_ABORT, 32'h0000_0004);
      wr(dtp_pkg::OFS_IRQ_MSK, 32'h0000_0000);
      repeat (2) @(posedge core_clk_i);
      chk(irq_o, 1'b0, "irq masked");
      wr(dtp_pkg::OFS_ABORT, 32'h0000_0004);
      xfer(4'h1, 32'h0000_0000, 3'h0);
      chk(channel_abort_flag_o, 32'h0000_0000, "abort cleared");
      $display("test nmi done");
   endtask

   ////////////////////////////////////////////////////////////////////////////
   // Clock, timeout and main sequence
   task automatic results();
      $display("compares %0d failures %0d", compares, failures);
      if (failures == 0 && compares > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   initial begin
      core_clk_i = 1'b0;
      forever #5 core_clk_i = ~core_clk_i;
   end
   always @(posedge core_clk_i) begin
      cyc <= cyc + 1;
      if (cyc == 5000) begin
         failures++;
         results();
      end
   end
   initial begin
      {rst_n_i, s_axi_awvalid_i, s_axi_wvalid_i, s_axi_bready_i, s_axi_arvalid_i, s_axi_rready_i} = '0;
      {cpu_rmw_i, nmi_i, slow, s_axi_awaddr_i, s_axi_araddr_i, s_axi_wdata_i, trig_i, ch_req_lo_i} = '0;
      s_axi_wstrb_i = 4'hF;
      repeat (3) @(posedge core_clk_i);
      rst_n_i <= 1'b1;
      t_regs();
      t_route();
      t_prio();
      t_rmw();
      t_nmi();
      results();
   end
endmodule // tb_dma_trigger_priority_control
